// ### hw/slr_pkg.sv
// Package: register map, field layout, reset values and timing for the setpoint block
package slr_pkg;
    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_LOCAL = 8'h04;
    localparam logic [7:0] OFS_BOUNDS = 8'h08;
    localparam logic [7:0] OFS_RAMP = 8'h0C;
    localparam logic [7:0] OFS_HTHR = 8'h10;
    localparam logic [7:0] OFS_RANGE = 8'h14;
    localparam logic [7:0] OFS_RSCALE = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    localparam logic [7:0] OFS_TGTMON = 8'h20;
    localparam logic [7:0] OFS_HCUR = 8'h24;
    localparam logic [7:0] OFS_RMON = 8'h28;

    // ****************************************
    // CTRL field positions
    // ****************************************
    localparam int B_RUN = 0;
    localparam int B_MANUAL = 1;
    localparam int B_ONOFF = 2;
    localparam int B_AT_REQ = 3;
    localparam int B_RT_EN = 4;
    localparam int B_SRC_REM = 5;
    localparam int B_FOLLOW = 6;
    localparam int B_LATCH = 7;
    localparam int B_STD = 8;
    localparam int B_PULSED = 9;
    localparam int B_ALM_ASG = 10;
    localparam int B_RERR_ASG = 11;
    localparam int B_UNIT_MIN = 12;
    localparam int CTRL_W = 13;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [12:0] CTRL_RST = 13'h0000;
    localparam logic signed [15:0] LO_RST = 16'sh0000;
    localparam logic signed [15:0] HI_RST = 16'sh03E8;
    localparam logic [15:0] RATE_RST = 16'h0000;
    localparam logic [9:0] THR_RST = 10'h000;

    // ****************************************
    // Encodings and limits (0.1 A, 0.1 %)
    // ****************************************
    localparam logic [9:0] THR_OFF = 10'h000;
    localparam logic [9:0] THR_FORCE_ON = 10'h1F4;
    localparam logic [9:0] CUR_OVF = 10'h226;
    localparam logic [15:0] OVF_CODE = 16'hFFFF;
    localparam logic signed [15:0] PCT_LO = -16'sh0064;
    localparam logic signed [15:0] PCT_HI = 16'sh044C;
    localparam logic signed [31:0] PCT_DIV = 32'sh000003E8;
    localparam logic [5:0] SEC_PER_MIN = 6'h3C;

    // ****************************************
    // Timing
    // ****************************************
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned RAMP_UNIT_S = 1;
    localparam int unsigned SEC_CYCLES = RAMP_UNIT_S * CLK_HZ;
    localparam int unsigned HEAT_ON_MS = 190;
    localparam int unsigned HEAT_ON_CYCLES = (HEAT_ON_MS * CLK_HZ + 999) / 1000;

    // ****************************************
    // Block state
    // ****************************************
    typedef struct packed {
        logic [12:0] ctrl;
        logic signed [15:0] local_tgt;
        logic signed [15:0] lo_b;
        logic signed [15:0] hi_b;
        logic [15:0] rate;
        logic [9:0] thr;
        logic signed [15:0] rs_lo;
        logic signed [15:0] rs_hi;
        logic signed [15:0] ramp_cur;
        logic [31:0] tick_cnt;
        logic [5:0] sec_cnt;
        logic [31:0] on_cnt;
        logic alarm;
        logic at_pend;
        logic at_run;
        logic signed [15:0] at_tgt;
        logic run_d;
        logic rem_d;
        logic init_pend;
        logic [31:0] prdata;
    } slr_state_t;
endpackage : slr_pkg

// ### hw/slr_core.sv
// Setpoint limiting, ramping, remote target selection and heater open alarm with APB registers
//
// Contract
// RULE_01: Output limiters off in on/off, manual, stop, error; rate limiter also off in autotune.
// RULE_02: When bounds are re-established, a target outside them is forced to the bound.
// RULE_03: Input type, unit or range change resets target bounds to the full range.
// RULE_04: Target changes ramp at rate per unit; a rate of zero disables ramping.
// RULE_05: At power-up and stop-to-run the ramp starts from the process value.
// RULE_06: Autotune requested during a ramp starts only after the ramp ends.
// RULE_07: In manual mode the intermediate target keeps advancing until the ramp ends.
// RULE_08: Ramp is suspended while stopped or while an error is present.
// RULE_09: Remote target used only while remote target enable is on.
// RULE_10: Remote input accepted over -10 to 110 %; outside clamps to scaled limit and blinks.
// RULE_11: Out-of-range remote raises the remote error output and selects the error drive level.
// RULE_12: Changing a target bound copies both bounds into the remote scaling limits.
// RULE_13: Target source picks remote or local; remote indicator lit while remote selected.
// RULE_14: Remote-to-local with follow loads local with the used target, else keeps old local.
// RULE_15: Local-to-remote switching ramps toward the new target when ramping is enabled.
// RULE_16: During autotune the remote input is ignored; tuning uses the target captured at start.
// RULE_17: Heater alarm allowed only with pulsed heat output on standard variant, and when assigned.
// RULE_18: Heater current below threshold raises the heater open alarm; control continues.
// RULE_19: With latch on the alarm holds until the threshold is 0.0 A or reset.
// RULE_20: Heater detection only after the control output has been on for 190 ms.
// RULE_21: Thresholds 0.1..49.9 A detect; 0.0 forces off, 50.0 forces on.
// RULE_22: Heater current of 55.0 A or more reads back as FFFF.
// RULE_23: Intermediate target steps by the rate once per unit and stops exactly at the target.
`timescale 1ns/1ps
module slr_core #(
    parameter int unsigned RAMP_SEC_CYCLES = slr_pkg::SEC_CYCLES,
    parameter int unsigned HEAT_ON_CNT = slr_pkg::HEAT_ON_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic signed [15:0] process_value,
    input wire logic signed [15:0] remote_pct,
    input wire logic [9:0] heater_current,
    input wire logic heat_out_on,
    input wire logic error_in,
    input wire logic at_done,
    output logic signed [15:0] target_value,
    output logic limiter_en,
    output logic rate_limiter_en,
    output logic at_running,
    output logic remote_ind_on,
    output logic remote_ind_blink,
    output logic remote_err_out,
    output logic error_drive_sel,
    output logic heater_open_alarm
);
    slr_pkg::slr_state_t s_r;
    slr_pkg::slr_state_t s_nxt;

    // ****************************************
    // Decoded controls and derived values
    // ****************************************
    logic run, manual, onoff, use_remote, rem_err, ramping, unit_tick, sec_tick;
    logic wr, rd_setup, mapped;
    logic [7:0] ofs;
    logic signed [15:0] rem_val, sel_tgt, fin_tgt;
    logic signed [31:0] rem_prod;
    logic signed [16:0] gap;
    logic [15:0] hmon;
    logic alarm_allowed, on_long;

    assign run = s_r.ctrl[slr_pkg::B_RUN];
    assign manual = s_r.ctrl[slr_pkg::B_MANUAL];
    assign onoff = s_r.ctrl[slr_pkg::B_ONOFF];
    assign ofs = paddr[7:0];
    assign wr = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;

    // Decode is exact on the full address so aliases answer as errors
    always_comb begin
        case (ofs)
            slr_pkg::OFS_CTRL, slr_pkg::OFS_LOCAL, slr_pkg::OFS_BOUNDS, slr_pkg::OFS_RAMP,
            slr_pkg::OFS_HTHR, slr_pkg::OFS_RANGE, slr_pkg::OFS_RSCALE, slr_pkg::OFS_STATUS,
            slr_pkg::OFS_TGTMON, slr_pkg::OFS_HCUR, slr_pkg::OFS_RMON: mapped = (paddr[31:8] == 24'h000000);
            default: mapped = 1'b0;
        endcase
    end

    // Zero wait states; unmapped access completes with an error
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata = s_r.prdata;

    // Remote scaling; out-of-span input pins to the scaled limit
    assign rem_prod = 32'(remote_pct) * 32'(s_r.rs_hi - s_r.rs_lo);
    assign rem_err = (remote_pct < slr_pkg::PCT_LO) | (remote_pct > slr_pkg::PCT_HI);
    always_comb begin
        if (remote_pct < slr_pkg::PCT_LO) begin
            rem_val = s_r.rs_lo; // RULE_10
        end else if (remote_pct > slr_pkg::PCT_HI) begin
            rem_val = s_r.rs_hi; // RULE_10
        end else begin
            rem_val = s_r.rs_lo + 16'(rem_prod / slr_pkg::PCT_DIV);
        end
    end

    // Target source; autotune freezes the target it started on
    assign use_remote = s_r.ctrl[slr_pkg::B_RT_EN] & s_r.ctrl[slr_pkg::B_SRC_REM]; // RULE_09
    always_comb begin
        if (s_r.at_run) begin
            sel_tgt = s_r.at_tgt; // RULE_16
        end else if (use_remote) begin
            sel_tgt = rem_val; // RULE_13
        end else begin
            sel_tgt = s_r.local_tgt;
        end
        if (sel_tgt > s_r.hi_b) begin
            fin_tgt = s_r.hi_b;
        end else if (sel_tgt < s_r.lo_b) begin
            fin_tgt = s_r.lo_b;
        end else begin
            fin_tgt = sel_tgt;
        end
    end

    // Ramp time base: seconds, and minutes built from sixty of them
    assign sec_tick = (s_r.tick_cnt == 32'(RAMP_SEC_CYCLES - 1));
    assign unit_tick = sec_tick & (~s_r.ctrl[slr_pkg::B_UNIT_MIN] | (s_r.sec_cnt == slr_pkg::SEC_PER_MIN - 6'h01));
    assign ramping = (s_r.ramp_cur != fin_tgt);
    assign gap = 17'(fin_tgt) - 17'(s_r.ramp_cur);

    // Heater alarm qualification
    assign alarm_allowed = (~s_r.ctrl[slr_pkg::B_STD] | s_r.ctrl[slr_pkg::B_PULSED])
        & s_r.ctrl[slr_pkg::B_ALM_ASG]; // RULE_17
    assign on_long = (s_r.on_cnt >= 32'(HEAT_ON_CNT)); // RULE_20
    assign hmon = (heater_current >= slr_pkg::CUR_OVF) ? slr_pkg::OVF_CODE : 16'(heater_current); // RULE_22

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        s_nxt = s_r;
        s_nxt.run_d = run;
        s_nxt.rem_d = use_remote;
        s_nxt.init_pend = 1'b0;

        // Register writes; hardware updates below take priority over a racing write, except that a CTRL write wins over the autotune request clear
        if (wr & mapped) begin
            case (ofs)
                slr_pkg::OFS_CTRL: s_nxt.ctrl = pwdata[slr_pkg::CTRL_W-1:0];
                slr_pkg::OFS_LOCAL: s_nxt.local_tgt = pwdata[15:0];
                slr_pkg::OFS_BOUNDS: begin
                    s_nxt.lo_b = pwdata[15:0];
                    s_nxt.hi_b = pwdata[31:16];
                end
                slr_pkg::OFS_RAMP: s_nxt.rate = pwdata[15:0];
                slr_pkg::OFS_HTHR: s_nxt.thr = pwdata[9:0];
                slr_pkg::OFS_RANGE: begin
                    s_nxt.lo_b = pwdata[15:0]; // RULE_03
                    s_nxt.hi_b = pwdata[31:16]; // RULE_03
                end
                slr_pkg::OFS_RSCALE: begin
                    s_nxt.rs_lo = pwdata[15:0];
                    s_nxt.rs_hi = pwdata[31:16];
                end
                default: s_nxt.ctrl = s_r.ctrl;
            endcase
        end

        // Bound change: copy to remote scaling and pull the local target inside
        if (wr & mapped & ((ofs == slr_pkg::OFS_BOUNDS) | (ofs == slr_pkg::OFS_RANGE))) begin
            s_nxt.rs_lo = pwdata[15:0]; // RULE_12
            s_nxt.rs_hi = pwdata[31:16]; // RULE_12
            if (s_nxt.local_tgt > $signed(pwdata[31:16])) begin
                s_nxt.local_tgt = pwdata[31:16]; // RULE_02
            end else if (s_nxt.local_tgt < $signed(pwdata[15:0])) begin
                s_nxt.local_tgt = pwdata[15:0]; // RULE_02
            end
        end

        // Leaving remote: follow keeps the target in use, otherwise the old local stays
        if (s_r.rem_d & ~use_remote & s_r.ctrl[slr_pkg::B_FOLLOW]) begin
            s_nxt.local_tgt = s_r.ramp_cur; // RULE_14
        end

        // Autotune waits for the ramp, ends on done or when operation stops
        if (s_r.ctrl[slr_pkg::B_AT_REQ] & ~s_r.at_run & ~(wr & (ofs == slr_pkg::OFS_CTRL))) begin
            s_nxt.at_pend = 1'b1;
            s_nxt.ctrl[slr_pkg::B_AT_REQ] = 1'b0;
        end
        if (s_r.at_pend & ~ramping & run & ~error_in) begin
            s_nxt.at_pend = 1'b0; // RULE_06
            s_nxt.at_run = 1'b1; // RULE_06
            s_nxt.at_tgt = fin_tgt; // RULE_16
        end
        if (s_r.at_run & (at_done | ~run | error_in)) begin
            s_nxt.at_run = 1'b0;
        end

        // Ramp engine; runs in manual as well, only stop and error suspend it
        if (s_r.init_pend | (run & ~s_r.run_d)) begin
            s_nxt.ramp_cur = (s_r.rate == 16'h0000) ? fin_tgt : process_value; // RULE_05
            s_nxt.tick_cnt = 32'h00000000;
            s_nxt.sec_cnt = 6'h00;
        end else if (~run | error_in | (s_r.rate == 16'h0000)) begin
            s_nxt.ramp_cur = fin_tgt; // RULE_08
            s_nxt.tick_cnt = 32'h00000000;
            s_nxt.sec_cnt = 6'h00;
        end else if (ramping) begin
            // A source switch just changes fin_tgt, so it ramps too // RULE_15
            s_nxt.tick_cnt = sec_tick ? 32'h00000000 : s_r.tick_cnt + 32'h00000001; // RULE_07
            if (sec_tick) begin
                s_nxt.sec_cnt = unit_tick ? 6'h00 : s_r.sec_cnt + 6'h01;
            end
            if (unit_tick) begin
                if (gap > $signed({1'b0, s_r.rate})) begin
                    s_nxt.ramp_cur = 16'(17'(s_r.ramp_cur) + {1'b0, s_r.rate}); // RULE_23
                end else if (gap < -$signed({1'b0, s_r.rate})) begin
                    s_nxt.ramp_cur = 16'(17'(s_r.ramp_cur) - {1'b0, s_r.rate}); // RULE_23
                end else begin
                    s_nxt.ramp_cur = fin_tgt; // RULE_04
                end
            end
        end else begin
            s_nxt.tick_cnt = 32'h00000000;
            s_nxt.sec_cnt = 6'h00;
        end

        // On-time counter saturates so it cannot wrap during long on periods
        if (~heat_out_on) begin
            s_nxt.on_cnt = 32'h00000000;
        end else if (~on_long) begin
            s_nxt.on_cnt = s_r.on_cnt + 32'h00000001;
        end

        // Heater alarm; detection never touches the control path
        if (~alarm_allowed | (s_r.thr == slr_pkg::THR_OFF)) begin
            s_nxt.alarm = 1'b0; // RULE_21 RULE_19
        end else if (s_r.thr >= slr_pkg::THR_FORCE_ON) begin
            s_nxt.alarm = 1'b1; // RULE_21
        end else if (on_long & heat_out_on) begin
            if (heater_current < s_r.thr) begin
                s_nxt.alarm = 1'b1; // RULE_18
            end else if (~s_r.ctrl[slr_pkg::B_LATCH]) begin
                s_nxt.alarm = 1'b0; // RULE_19
            end
        end

        // Read data captured in the setup phase, stable through the access phase
        if (rd_setup) begin
            case (ofs)
                slr_pkg::OFS_CTRL: s_nxt.prdata = 32'(s_r.ctrl);
                slr_pkg::OFS_LOCAL: s_nxt.prdata = {16'h0000, s_r.local_tgt};
                slr_pkg::OFS_BOUNDS: s_nxt.prdata = {s_r.hi_b, s_r.lo_b};
                slr_pkg::OFS_RAMP: s_nxt.prdata = {16'h0000, s_r.rate};
                slr_pkg::OFS_HTHR: s_nxt.prdata = {22'h000000, s_r.thr};
                slr_pkg::OFS_RANGE: s_nxt.prdata = {s_r.hi_b, s_r.lo_b};
                slr_pkg::OFS_RSCALE: s_nxt.prdata = {s_r.rs_hi, s_r.rs_lo};
                slr_pkg::OFS_STATUS: s_nxt.prdata = {25'h0000000, use_remote, rate_limiter_en,
                    limiter_en, s_r.at_run, ramping, rem_err, s_r.alarm};
                slr_pkg::OFS_TGTMON: s_nxt.prdata = {fin_tgt, s_r.ramp_cur};
                slr_pkg::OFS_HCUR: s_nxt.prdata = {16'h0000, hmon};
                slr_pkg::OFS_RMON: s_nxt.prdata = {16'h0000, rem_val};
                default: s_nxt.prdata = 32'h00000000;
            endcase
            if (~mapped) begin
                s_nxt.prdata = 32'h00000000;
            end
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_r <= '0;
            s_r.ctrl <= slr_pkg::CTRL_RST;
            s_r.lo_b <= slr_pkg::LO_RST;
            s_r.hi_b <= slr_pkg::HI_RST;
            s_r.rs_lo <= slr_pkg::LO_RST;
            s_r.rs_hi <= slr_pkg::HI_RST;
            s_r.rate <= slr_pkg::RATE_RST;
            s_r.thr <= slr_pkg::THR_RST;
            s_r.init_pend <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign target_value = s_r.ramp_cur;
    assign limiter_en = ~(onoff | manual | ~run | error_in); // RULE_01
    assign rate_limiter_en = limiter_en & ~s_r.at_run; // RULE_01
    assign at_running = s_r.at_run;
    assign remote_ind_on = use_remote; // RULE_13
    assign remote_ind_blink = use_remote & rem_err & ~s_r.at_run; // RULE_10
    assign remote_err_out = use_remote & rem_err & ~s_r.at_run & s_r.ctrl[slr_pkg::B_RERR_ASG]; // RULE_11
    assign error_drive_sel = use_remote & rem_err & ~s_r.at_run; // RULE_11
    assign heater_open_alarm = s_r.alarm;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_bound_wr;
        wr & mapped & (ofs == slr_pkg::OFS_BOUNDS);
    endsequence
    sequence s_leave_remote;
        s_r.rem_d & ~use_remote & s_r.ctrl[slr_pkg::B_FOLLOW];
    endsequence

    property p_lim_off;
        (manual | onoff | ~run | error_in) |-> ~limiter_en & ~rate_limiter_en;
    endproperty
    a_lim_off: assert property (p_lim_off) else $error("limiter enabled in a blocked mode"); // RULE_01

    property p_bound_clamp;
        s_bound_wr |=> (s_r.local_tgt <= s_r.hi_b) && (s_r.local_tgt >= s_r.lo_b) || s_r.lo_b > s_r.hi_b;
    endproperty
    a_bound_clamp: assert property (p_bound_clamp) else $error("local target left outside bounds"); // RULE_02

    property p_rs_copy;
        s_bound_wr |=> (s_r.rs_lo == s_r.lo_b) && (s_r.rs_hi == s_r.hi_b);
    endproperty
    a_rs_copy: assert property (p_rs_copy) else $error("remote scaling not updated"); // RULE_12

    property p_range_reset;
        wr & mapped & (ofs == slr_pkg::OFS_RANGE) |=> s_r.hi_b == $past(pwdata[31:16])
            && s_r.lo_b == $past(pwdata[15:0]);
    endproperty
    a_range_reset: assert property (p_range_reset) else $error("bounds not reset to range"); // RULE_03

    property p_step;
        run & ~error_in & ramping & unit_tick & ~s_r.init_pend & s_r.run_d & (s_r.rate != 16'h0000) |=>
            (s_r.ramp_cur - $past(s_r.ramp_cur) <= $signed({1'b0, $past(s_r.rate)}))
            && ($past(s_r.ramp_cur) - s_r.ramp_cur <= $signed({1'b0, $past(s_r.rate)}))
            && (s_r.ramp_cur != $past(s_r.ramp_cur));
    endproperty
    a_step: assert property (p_step) else $error("ramp step wrong size"); // RULE_23

    property p_run_load;
        run & ~s_r.run_d & (s_r.rate != 16'h0000) |=> s_r.ramp_cur == $past(process_value);
    endproperty
    a_run_load: assert property (p_run_load) else $error("ramp did not start at process value"); // RULE_05

    property p_at_defer;
        s_r.at_pend & ramping & ~s_r.at_run |=> ~s_r.at_run;
    endproperty
    a_at_defer: assert property (p_at_defer) else $error("autotune started during ramp"); // RULE_06

    property p_stop;
        ~run & ~s_r.init_pend & ~$past(run) |=> s_r.ramp_cur == $past(fin_tgt);
    endproperty
    a_stop: assert property (p_stop) else $error("ramp active while stopped"); // RULE_08

    property p_rem_clamp;
        remote_pct > slr_pkg::PCT_HI |-> rem_val == s_r.rs_hi;
    endproperty
    a_rem_clamp: assert property (p_rem_clamp) else $error("remote not clamped high"); // RULE_10

    property p_follow;
        s_leave_remote |=> s_r.local_tgt == $past(s_r.ramp_cur);
    endproperty
    a_follow: assert property (p_follow) else $error("follow did not load local target"); // RULE_14

    property p_force_on;
        (alarm_allowed & (s_r.thr >= slr_pkg::THR_FORCE_ON)) [*2] |-> heater_open_alarm;
    endproperty
    a_force_on: assert property (p_force_on) else $error("forced alarm not on"); // RULE_21

    property p_no_early;
        $rose(heater_open_alarm) & (s_r.thr != slr_pkg::THR_OFF) & ($past(s_r.thr) < slr_pkg::THR_FORCE_ON)
            |-> $past(on_long) & $past(heat_out_on);
    endproperty
    a_no_early: assert property (p_no_early) else $error("alarm before output on long enough"); // RULE_20

    property p_latch_hold;
        heater_open_alarm & s_r.ctrl[slr_pkg::B_LATCH] & alarm_allowed & (s_r.thr != slr_pkg::THR_OFF)
            & ~(wr & mapped) |=> heater_open_alarm;
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latched alarm dropped"); // RULE_19
endmodule : slr_core

// ### verif/slr_far_model.sv
// Far-side model: process sensor, remote loop source and heater current sensor
`timescale 1ns/1ps
module slr_far_model #(
    parameter logic signed [15:0] PV_INIT = 16'sh0004
) (
    input wire logic ref_clk,
    input wire logic heat_req,
    input wire logic err_req,
    input wire logic [9:0] cur_req,
    input wire logic signed [15:0] pct_req,
    output logic signed [15:0] process_value,
    output logic signed [15:0] remote_pct,
    output logic [9:0] heater_current,
    output logic heat_out_on,
    output logic error_in,
    output logic at_done
);
    // Known levels from time zero
    initial begin
        process_value = PV_INIT;
        remote_pct = 16'sh0000;
        heater_current = 10'h000;
        heat_out_on = 1'b0;
        error_in = 1'b0;
        at_done = 1'b0;
    end
    // Sensor sees no current unless the heater is energised, so a stale value never lingers
    always @(posedge ref_clk) begin
        heat_out_on <= heat_req;
        heater_current <= heat_req ? cur_req : 10'h000;
        remote_pct <= pct_req;
        error_in <= err_req;
    end
endmodule : slr_far_model

// ### verif/tb_top.sv
// Testbench: registers, ramp, bounds, remote target and heater alarm of the setpoint block
`timescale 1ns/1ps
module tb_top;
    logic ref_clk, rst, psel, penable, pwrite, pready, heat_req, err_req;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic signed [15:0] process_value, remote_pct, target_value, pct_req;
    logic [9:0] heater_current, cur_req;
    logic heat_out_on, error_in, at_done, limiter_en, remote_ind_on, remote_ind_blink, heater_open_alarm;
    logic rate_limiter_en, at_running, remote_err_out, error_drive_sel;
    int bad_count, checks_done;

    // Short counts keep the run brief: one ramp unit is 10 cycles, heater on-time 5 cycles
    slr_core #(.RAMP_SEC_CYCLES(10), .HEAT_ON_CNT(5)) i_dut (.ref_clk(ref_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(), .process_value(process_value), .remote_pct(remote_pct), .heater_current(heater_current),
        .heat_out_on(heat_out_on), .error_in(error_in), .at_done(at_done), .target_value(target_value),
        .limiter_en(limiter_en), .rate_limiter_en(rate_limiter_en), .at_running(at_running),
        .remote_ind_on(remote_ind_on), .remote_ind_blink(remote_ind_blink), .remote_err_out(remote_err_out),
        .error_drive_sel(error_drive_sel),
        .heater_open_alarm(heater_open_alarm));
    slr_far_model i_far (.ref_clk(ref_clk), .heat_req(heat_req), .err_req(err_req), .cur_req(cur_req),
        .pct_req(pct_req), .process_value(process_value), .remote_pct(remote_pct),
        .heater_current(heater_current), .heat_out_on(heat_out_on), .error_in(error_in), .at_done(at_done));

    // 10 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    task automatic print_verdict;
        $display("checks=%0d mismatches=%0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // Settled sampling away from the rising edge
    task automatic wt(input int k);
        repeat (k) @(negedge ref_clk);
    endtask : wt
    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= {24'h000000, a}; pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            bad_count++;
            print_verdict();
        end
        q = prdata;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task automatic t_regs;
        apb(0, 8'h00, 0, rd); chk(rd, 32'h00000000);
        apb(0, 8'h08, 0, rd); chk(rd, 32'h03E80000);
        apb(0, 8'h30, 0, rd); chk(rd, 32'h00000000);
        $display("registers done");
    endtask : t_regs
    task automatic t_ramp;
        apb(1, 8'h0C, 32'h3, rd); apb(1, 8'h04, 32'hA, rd); apb(1, 8'h00, 32'h9, rd);
        wt(2); chk(target_value, 16'h0004);
        wt(12); chk(target_value, 16'h0007);
        chk(at_running, 1'b0);
        wt(10); chk(target_value, 16'h000A);
        chk(at_running, 1'b1);
        apb(1, 8'h04, 32'h14, rd); wt(12); chk(target_value, 16'h000A);
        chk(limiter_en, 1'b1);
        chk(rate_limiter_en, 1'b0);
        err_req <= 1'b1; wt(3); chk(limiter_en, 1'b0);
        err_req <= 1'b0;
        apb(1, 8'h0C, 32'h0, rd); apb(1, 8'h04, 32'h1E, rd);
        wt(2); chk(target_value, 16'h001E);
        $display("ramp done");
    endtask : t_ramp
    task automatic t_bounds;
        apb(1, 8'h08, 32'h000F0000, rd);
        apb(0, 8'h04, 0, rd); chk(rd[15:0], 16'h000F);
        apb(0, 8'h18, 0, rd); chk(rd, 32'h000F0000);
        apb(1, 8'h14, 32'h03200000, rd);
        apb(0, 8'h08, 0, rd); chk(rd, 32'h03200000);
        $display("bounds done");
    endtask : t_bounds
    task automatic t_remote;
        apb(1, 8'h00, 32'h831, rd);
        pct_req <= 16'sh04B0; wt(3); chk(remote_ind_on, 1'b1);
        chk(remote_ind_blink, 1'b1);
        chk(remote_err_out, 1'b1);
        chk(error_drive_sel, 1'b1);
        pct_req <= 16'sh01F4; wt(3); chk(remote_ind_blink, 1'b0);
        apb(0, 8'h28, 0, rd); chk(rd[15:0], 16'h0190);
        apb(1, 8'h00, 32'h51, rd); apb(0, 8'h04, 0, rd); chk(rd[15:0], 16'h0190);
        $display("remote done");
    endtask : t_remote
    task automatic t_heater;
        apb(1, 8'h00, 32'h781, rd); apb(1, 8'h10, 32'h64, rd);
        cur_req <= 10'h032; heat_req <= 1'b1;
        wt(3); chk(heater_open_alarm, 1'b0);
        wt(8); chk(heater_open_alarm, 1'b1);
        cur_req <= 10'h0C8; wt(10); chk(heater_open_alarm, 1'b1);
        apb(1, 8'h10, 32'h0, rd); wt(2); chk(heater_open_alarm, 1'b0);
        apb(1, 8'h10, 32'h1F4, rd); wt(2); chk(heater_open_alarm, 1'b1);
        cur_req <= 10'h226; wt(3);
        apb(0, 8'h24, 0, rd); chk(rd[15:0], 16'hFFFF);
        $display("heater done");
    endtask : t_heater
    // Main sequence
    initial begin
        bad_count = 0; checks_done = 0; rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 32'h0; pwdata = 32'h0; heat_req = 1'b0; err_req = 1'b0; cur_req = 10'h0; pct_req = 16'sh0;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        t_regs(); t_ramp(); t_bounds(); t_remote(); t_heater();
        print_verdict();
    end
endmodule : tb_top
